// ---- hw/spi_port_defines.svh ----
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

// APB byte addresses
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_BUFFER     8'h08
`define ADDR_AUX        8'h0C

// Control register one fields
`define CTRL_COLLIDE    7
`define CTRL_OV         6
`define CTRL_EN         5
`define CTRL_IDLE_POL   4
`define CTRL_RST        8'h00

// Status register fields
`define STAT_PHASE      7
`define STAT_CKE        6
`define STAT_FULL       0
`define STAT_RST        8'h00

// Auxiliary register fields
`define AUX_DONE        0
`define AUX_SDO_DRV     1
`define AUX_SCK_PIN     2
`define AUX_BUSY        3

// Mode select codes
`define MODE_MST_DIV4   4'h0
`define MODE_MST_DIV16  4'h1
`define MODE_MST_DIV64  4'h2
`define MODE_MST_TMR    4'h3
`define MODE_SLV_SS     4'h4
`define MODE_SLV_NOSS   4'h5

// Rate select (low mode bits) and half-bit terminal counts in pclk cycles
`define RATE_DIV4       2'h0
`define RATE_DIV16      2'h1
`define RATE_TMR        2'h3
`define HALF_DIV4       5'h01
`define HALF_DIV16      5'h07
`define HALF_DIV64      5'h1F

// Word framing
`define LAST_EDGE       4'hF
`define LAST_BIT        3'h7

`endif

// ---- hw/spi_port_pkg.sv ----
package spi_port_pkg;

	typedef struct packed {
		logic       write_collision_flag;
		logic       ov;
		logic       en;
		logic       clock_idle_polarity;
		logic [3:0] mode;
	} ctrl_t;

	typedef struct packed {
		logic sck;
		logic sdi;
		logic ss_n;
	} pin_in_t;

	typedef struct packed {
		logic sck;
		logic sck_oe;
		logic sdo;
		logic sdo_oe;
	} pin_out_t;

	typedef enum logic {
		MST_IDLE,
		MST_SHIFT
	} mst_state_t;

endpackage

// ---- hw/spi_rate_gen.sv ----
`timescale 1ns/1ps
`include "spi_port_defines.svh"

module spi_rate_gen (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [1:0] rate_sel,
	input  wire logic       timer_two_output,
	output logic            half_tick
);

	logic [4:0] cnt_ff;
	logic [4:0] nxt_cnt;
	logic [4:0] terminal;
	logic       cnt_hit;

	assign terminal = (rate_sel == `RATE_DIV4)  ? `HALF_DIV4 :
	                  (rate_sel == `RATE_DIV16) ? `HALF_DIV16 : `HALF_DIV64;
	assign cnt_hit  = (cnt_ff == terminal);
	assign nxt_cnt  = (!run || cnt_hit) ? 5'h00 : cnt_ff + 5'h01;

	// Each timer pulse is half a bit, so the bit rate is the timer rate over two
	assign half_tick = run && ((rate_sel == `RATE_TMR) ? timer_two_output : cnt_hit);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_ff <= 5'h00;
		else
			cnt_ff <= nxt_cnt;
	end

endmodule

// ---- hw/spi_serial_port.sv ----
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "spi_port_defines.svh"

module spi_serial_port (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire spi_port_pkg::pin_in_t    pins_in,
	input  wire logic                     timer_two_output,
	output spi_port_pkg::pin_out_t        pins_out,
	output logic                          transfer_done_irq_flag,
	output logic                          wake_request
);

	function automatic logic is_master_mode(input logic [3:0] m);
		is_master_mode = (m[3:2] == 2'b00);
	endfunction

	function automatic logic is_slave_mode(input logic [3:0] m);
		is_slave_mode = (m == `MODE_SLV_SS) || (m == `MODE_SLV_NOSS);
	endfunction

	spi_port_pkg::ctrl_t      ctrl_ff;
	spi_port_pkg::ctrl_t      nxt_ctrl;
	spi_port_pkg::pin_in_t    sync1_ff;
	spi_port_pkg::pin_in_t    sync2_ff;
	spi_port_pkg::pin_out_t   pins_ff;
	spi_port_pkg::pin_out_t   nxt_pins;
	spi_port_pkg::mst_state_t state_ff;
	spi_port_pkg::mst_state_t nxt_state;

	logic        sample_phase_ff;
	logic        cke_ff;
	logic        buffer_full_ff;
	logic        nxt_buffer_full;
	logic        done_ff;
	logic        nxt_done;
	logic        sdo_drv_ff;
	logic        wake_ff;
	logic [7:0]  buf_ff;
	logic [7:0]  nxt_buf;
	logic [7:0]  sh_ff;
	logic [7:0]  nxt_sh;
	logic        latch_ff;
	logic [3:0]  edge_ff;
	logic [2:0]  bits_ff;
	logic        sck_prev_ff;
	logic [31:0] prdata_ff;
	logic [31:0] rd_data;
	logic        pready_ff;
	logic        pslverr_ff;

	// Bus decode
	logic setup;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic hit_ctrl;
	logic hit_stat;
	logic hit_buf;
	logic hit_aux;
	logic mapped;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_buf;
	logic wr_aux;
	logic rd_buf;

	assign setup    = psel && !penable;
	assign acc      = psel && penable && pready_ff;
	assign wr_acc   = acc && pwrite;
	assign rd_acc   = acc && !pwrite;
	assign hit_ctrl = (paddr == `ADDR_CTRL);
	assign hit_stat = (paddr == `ADDR_STATUS);
	assign hit_buf  = (paddr == `ADDR_BUFFER);
	assign hit_aux  = (paddr == `ADDR_AUX);
	assign mapped   = hit_ctrl || hit_stat || hit_buf || hit_aux;
	assign wr_ctrl  = wr_acc && hit_ctrl;
	assign wr_stat  = wr_acc && hit_stat;
	assign wr_buf   = wr_acc && hit_buf;
	assign wr_aux   = wr_acc && hit_aux;
	assign rd_buf   = rd_acc && hit_buf;

	// Mode decode
	logic master;
	logic slave;
	logic slave_ss;
	logic active;
	logic ss_reset;
	logic eng_clr;
	logic busy;
	logic mst_run;

	assign master   = ctrl_ff.en && is_master_mode(ctrl_ff.mode);
	assign slave    = ctrl_ff.en && is_slave_mode(ctrl_ff.mode);
	assign slave_ss = slave && (ctrl_ff.mode == `MODE_SLV_SS);
	assign active   = master || slave;
	assign ss_reset = slave_ss && sync2_ff.ss_n;
	assign eng_clr  = !active || ss_reset;
	assign mst_run  = master && (state_ff == spi_port_pkg::MST_SHIFT);
	assign busy     = mst_run || (slave && (edge_ff != 4'h0));

	// Bit timing
	logic half_tick;

	spi_rate_gen u_rate (
		.pclk             (pclk),
		.presetn          (presetn),
		.run              (mst_run),
		.rate_sel         (ctrl_ff.mode[1:0]),
		.timer_two_output (timer_two_output),
		.half_tick        (half_tick)
	);

	// Edge events; slave clock passes the two-stage synchroniser first
	logic m_edge;
	logic s_edge;
	logic ev;
	logic is_lead;
	logic out_edge;
	logic shift_out;
	logic phase_eff;
	logic sample;
	logic complete;
	logic [7:0] rx_byte;

	assign m_edge   = mst_run && half_tick;
	assign s_edge   = slave && !ss_reset && (sync2_ff.sck != sck_prev_ff);
	assign ev       = m_edge || s_edge;
	// Slave judges edge sense from the level, so a missed edge does not flip it
	assign is_lead  = master ? !edge_ff[0] : (sync2_ff.sck != ctrl_ff.clock_idle_polarity);
	assign out_edge = ev && (cke_ff ? !is_lead : is_lead);
	// First leading edge with edge select clear only starts the MSB already shown
	assign shift_out = out_edge && (cke_ff || (edge_ff != 4'h0));
	// Sample phase is a master-only option
	assign phase_eff = sample_phase_ff && master;
	assign sample   = phase_eff ?
	                  ((out_edge && (edge_ff != 4'h0)) || (ev && edge_ff == `LAST_EDGE)) :
	                  (ev && !out_edge);
	assign complete = sample && (bits_ff == `LAST_BIT);
	assign rx_byte  = {sh_ff[6:0], sync2_ff.sdi};

	// Shift register: buffer write loads it, samples enter at the LSB
	always_comb
	begin
		nxt_sh = sh_ff;
		if (wr_buf && !busy)
			nxt_sh = pwdata[7:0];
		else if (shift_out && sample)
			nxt_sh = rx_byte;
		else if (shift_out)
			nxt_sh = {sh_ff[6:0], latch_ff};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sh_ff <= 8'h00;
		else
			sh_ff <= nxt_sh;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			latch_ff <= 1'b0;
		else if (sample)
			latch_ff <= sync2_ff.sdi;
	end

	// Edge and bit counters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			edge_ff <= 4'h0;
			bits_ff <= 3'h0;
		end
		else if (eng_clr)
		begin
			edge_ff <= 4'h0;
			bits_ff <= 3'h0;
		end
		else
		begin
			edge_ff <= edge_ff + {3'h0, ev};
			bits_ff <= bits_ff + {2'h0, sample};
		end
	end

	// Master sequencer
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			spi_port_pkg::MST_IDLE:
				if (master && wr_buf)
					nxt_state = spi_port_pkg::MST_SHIFT;
			spi_port_pkg::MST_SHIFT:
				if (m_edge && edge_ff == `LAST_EDGE)
					nxt_state = spi_port_pkg::MST_IDLE;
		endcase
		if (eng_clr)
			nxt_state = spi_port_pkg::MST_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_ff <= spi_port_pkg::MST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Buffer and flags; a hardware set beats a same-cycle software clear
	logic ovf_hit;
	logic clash_hit;

	assign clash_hit = wr_buf && busy;
	assign ovf_hit  = complete && slave && buffer_full_ff;
	assign nxt_buf  = (wr_buf && !busy) ? pwdata[7:0] :
	                  (complete && !ovf_hit) ? rx_byte : buf_ff;
	assign nxt_buffer_full = (complete && !ovf_hit) || (buffer_full_ff && !rd_buf);
	assign nxt_done = complete || (done_ff && !(wr_aux && pwdata[`AUX_DONE]));

	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl)
			nxt_ctrl = spi_port_pkg::ctrl_t'(pwdata[7:0]);
		// Only software clears these two
		nxt_ctrl.write_collision_flag = nxt_ctrl.write_collision_flag || clash_hit;
		nxt_ctrl.ov   = nxt_ctrl.ov || ovf_hit;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_ff <= spi_port_pkg::ctrl_t'(`CTRL_RST);
		else
			ctrl_ff <= nxt_ctrl;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buf_ff  <= 8'h00;
			buffer_full_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			buf_ff  <= nxt_buf;
			buffer_full_ff <= nxt_buffer_full;
			done_ff <= nxt_done;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sample_phase_ff <= 1'(`STAT_RST >> `STAT_PHASE);
			cke_ff     <= 1'b0;
			sdo_drv_ff <= 1'b0;
		end
		else
		begin
			if (wr_stat)
			begin
				sample_phase_ff <= pwdata[`STAT_PHASE];
				cke_ff <= pwdata[`STAT_CKE];
			end
			if (wr_aux)
				sdo_drv_ff <= pwdata[`AUX_SDO_DRV];
		end
	end

	// Wake request pulses for one pclk cycle on every slave byte, registered on pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_ff <= 1'b0;
		else
			wake_ff <= complete && slave;
	end

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_ff    <= 3'b001;
			sync2_ff    <= 3'b001;
			sck_prev_ff <= 1'b0;
		end
		else
		begin
			sync1_ff    <= pins_in;
			sync2_ff    <= sync1_ff;
			sck_prev_ff <= sync2_ff.sck;
		end
	end

	// Pin drive; nothing drives while the port is disabled
	always_comb
	begin
		nxt_pins.sck    = ctrl_ff.clock_idle_polarity ^ (mst_run && edge_ff[0]);
		nxt_pins.sck_oe = master;
		nxt_pins.sdo    = sh_ff[7];
		nxt_pins.sdo_oe = sdo_drv_ff &&
		                  (master || (slave && !slave_ss) ||
		                   (slave_ss && !sync2_ff.ss_n));
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pins_ff <= 4'h0;
		else
			pins_ff <= nxt_pins;
	end

	// Read data is captured in the setup cycle, so the slave never waits
	always_comb
	begin
		rd_data = 32'h0000_0000;
		if (hit_ctrl)
			rd_data = {24'h00_0000, ctrl_ff};
		else if (hit_stat)
			rd_data = {24'h00_0000, sample_phase_ff, cke_ff, 5'h00, buffer_full_ff};
		else if (hit_buf)
			rd_data = {24'h00_0000, buf_ff};
		else if (hit_aux)
			rd_data = {28'h000_0000, busy, sync2_ff.sck, sdo_drv_ff, done_ff};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
			pready_ff  <= 1'b0;
		end
		else
		begin
			pready_ff <= 1'b1;
			if (setup)
			begin
				prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
				pslverr_ff <= !mapped;
			end
		end
	end

	assign prdata                 = prdata_ff;
	assign pready                 = pready_ff;
	assign pslverr                = pslverr_ff;
	assign pins_out               = pins_ff;
	assign transfer_done_irq_flag = done_ff;
	assign wake_request           = wake_ff;

endmodule

// ---- tb/spi_port_sva.sv ----
`timescale 1ns/1ps
`include "spi_port_defines.svh"
module spi_port_sva (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire spi_port_pkg::pin_in_t  pins_in,
	input wire logic                   timer_two_output,
	input wire spi_port_pkg::pin_out_t pins_out,
	input wire logic                   transfer_done_irq_flag,
	input wire logic                   wake_request
);
	spi_port_pkg::ctrl_t ctrl_ff;
	wire logic acc = psel && penable;
	wire logic en = ctrl_ff.en;
	wire logic master = en && ctrl_ff.mode <= `MODE_MST_TMR;
	wire logic slave4 = en && ctrl_ff.mode == `MODE_SLV_SS;
	wire logic slave = slave4 || (en && ctrl_ff.mode == `MODE_SLV_NOSS);
	wire logic inert = !en || ctrl_ff.mode > `MODE_SLV_NOSS;
	wire logic aux_clr = acc && pwrite && paddr == `ADDR_AUX && pwdata[`AUX_DONE];
	// Shadow of the control register, taken from completed writes
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ctrl_ff <= '0;
		else if (acc && pready && pwrite && paddr == `ADDR_CTRL)
			ctrl_ff <= spi_port_pkg::ctrl_t'(pwdata[7:0]);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rise(m);
		$rose(pins_out.sck) && pins_out.sck_oe && !ctrl_ff.clock_idle_polarity &&
		ctrl_ff.mode == m;
	endsequence
	sequence s_unsel;
		(slave4 && pins_in.ss_n)[*4];
	endsequence
	a_port_inert: assert property (inert && $past(inert) |->
		!pins_out.sck_oe && !pins_out.sdo_oe) else $error("pins driven while inert");
	a_clock_dir: assert property ($stable(ctrl_ff) && en |->
		pins_out.sck_oe == master) else $error("clock direction wrong");
	a_idle_level: assert property ($rose(pins_out.sck_oe) |->
		pins_out.sck == ctrl_ff.clock_idle_polarity) else $error("clock idle level wrong");
	a_half_div4: assert property (s_rise(`MODE_MST_DIV4) |->
		##2 $fell(pins_out.sck)) else $error("core/4 half period wrong");
	a_half_div16: assert property (s_rise(`MODE_MST_DIV16) |->
		##8 $fell(pins_out.sck)) else $error("core/16 half period wrong");
	a_no_master_ovf: assert property (acc && !pwrite && paddr == `ADDR_CTRL && master
		|-> !prdata[`CTRL_OV]) else $error("overflow in master mode");
	a_wake_pulse: assert property (wake_request |-> slave ##1 !wake_request)
		else $error("wake request not a slave pulse");
	a_wake_done: assert property (wake_request |-> ##[0:2] transfer_done_irq_flag)
		else $error("done flag missing at byte end");
	a_done_sticky: assert property ($fell(transfer_done_irq_flag) && en && $past(en)
		|-> $past(aux_clr)) else $error("done flag dropped by itself");
	a_sdo_release: assert property (s_unsel |-> !pins_out.sdo_oe)
		else $error("data out driven while deselected");
endmodule
bind spi_serial_port spi_port_sva spi_port_sva_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
	.timer_two_output(timer_two_output), .pins_out(pins_out),
	.transfer_done_irq_flag(transfer_done_irq_flag), .wake_request(wake_request));

// ---- tb/spi_far_end.sv ----
`timescale 1ns/1ps
module spi_far_end (
	input  wire spi_port_pkg::pin_out_t pins_out,
	output spi_port_pkg::pin_in_t       pins_in
);
	logic [7:0] tx = 8'h00;
	logic [7:0] rx = 8'h00;
	logic       m_sck = 1'b0;
	logic       m_sdi = 1'b0;
	logic       m_ss_n = 1'b1;
	wire logic  sck_w = pins_out.sck_oe ? pins_out.sck : m_sck;
	assign pins_in = '{sck: sck_w, sdi: pins_out.sck_oe ? tx[7] : m_sdi, ss_n: m_ss_n};
	// Slave side: capture on rising, drive on falling
	always @(posedge sck_w)
		if (pins_out.sck_oe)
			// Undriven data out reads as the inverse, so a missing drive shows
			rx <= {rx[6:0], pins_out.sdo_oe ? pins_out.sdo : !pins_out.sdo};
	always @(negedge sck_w)
		if (pins_out.sck_oe)
			tx <= {tx[6:0], ~tx[0]};
	// Master side for slave tests; n below 8 aborts mid-byte
	task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
		// Off the core clock edge
		#5 m_ss_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			m_sdi = d[7 - i];
			#80 m_sck = 1'b1;
			q = {q[6:0], pins_out.sdo_oe ? pins_out.sdo : !pins_out.sdo};
			#80 m_sck = 1'b0;
		end
		#80 m_ss_n = 1'b1;
		// Released line must not keep the last bit
		m_sdi = ~m_sdi;
		// Deselect must stand long enough for the port to see it
		#160;
	endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "spi_port_defines.svh"
module testbench;
	logic                   pclk = 1'b0;
	logic                   presetn = 1'b0;
	logic                   psel = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite = 1'b0;
	logic                   tmr = 1'b0;
	logic [7:0]             paddr = 8'h00;
	logic [31:0]            pwdata = 32'h0;
	logic [31:0]            prdata;
	logic [31:0]            rd;
	logic                   pready;
	logic                   pslverr;
	logic                   err;
	logic                   irq;
	logic                   wake;
	logic [7:0]             got;
	logic [7:0]             rep;
	spi_port_pkg::pin_in_t  pins_in;
	spi_port_pkg::pin_out_t pins_out;
	int                     err_total = 0;
	int                     checked = 0;
	int                     cycles = 0;
	int                     wakes = 0;
	always #10 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cycles++;
		tmr <= cycles % 4 == 0;
		wakes += wake;
		if (cycles == 20000)
		begin
			err_total++;
			conclude();
		end
	end
	spi_serial_port spi_serial_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
		.timer_two_output(tmr), .pins_out(pins_out),
		.transfer_done_irq_flag(irq), .wake_request(wake));
	spi_far_end spi_far_end_inst (.pins_out(pins_out), .pins_in(pins_in));
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("FAIL at %0t: %s saw %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask
	// Poll busy rather than assume a transfer length
	task automatic wait_idle();
		rd = 32'h8;
		for (int i = 0; i < 300 && rd[`AUX_BUSY]; i++)
			apb(1'b0, `ADDR_AUX, 32'h0);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`ADDR_CTRL, 32'h0, "ctrl reset");
		rd_chk(`ADDR_STATUS, 32'h0, "status reset");
		rd_chk(8'h10, 32'h0, "unmapped read");
		chk(err, 1'b1, "unmapped error");
		$display("test reset done");
		apb(1'b1, `ADDR_AUX, 32'h2);
		// Fastest rate samples at end of bit to cover the input sync delay
		apb(1'b1, `ADDR_STATUS, 32'hC0);
		apb(1'b1, `ADDR_CTRL, 32'h20);
		spi_far_end_inst.tx = 8'hA5;
		apb(1'b1, `ADDR_BUFFER, 32'h3C);
		apb(1'b1, `ADDR_BUFFER, 32'h55);
		wait_idle();
		chk(spi_far_end_inst.rx, 8'h3C, "byte sent");
		chk(irq, 1'b1, "done flag");
		rd_chk(`ADDR_CTRL, 32'hA0, "collision");
		rd_chk(`ADDR_STATUS, 32'hC1, "full");
		rd_chk(`ADDR_BUFFER, 32'hA5, "byte got");
		rd_chk(`ADDR_STATUS, 32'hC0, "full cleared");
		rd_chk(`ADDR_CTRL, 32'hA0, "collision kept");
		$display("test master done");
		apb(1'b1, `ADDR_STATUS, 32'h40);
		for (int m = 1; m < 4; m++)
		begin
			rep = 8'(8'h0F + 8'h10 * m);
			apb(1'b1, `ADDR_CTRL, 32'h0);
			apb(1'b1, `ADDR_AUX, m == 3 ? 32'h1 : 32'h3);
			apb(1'b1, `ADDR_CTRL, 32'h20 | m);
			spi_far_end_inst.tx = rep;
			apb(1'b1, `ADDR_BUFFER, 32'hC0 | m);
			repeat (2) @(posedge pclk);
			#1 chk(pins_out.sdo_oe, m < 3, "data out drive");
			wait_idle();
			if (m < 3)
				chk(spi_far_end_inst.rx, 32'hC0 | m, "rate byte sent");
			rd_chk(`ADDR_BUFFER, rep, "rate byte got");
		end
		apb(1'b1, `ADDR_CTRL, 32'h0);
		apb(1'b1, `ADDR_CTRL, 32'h26);
		apb(1'b1, `ADDR_BUFFER, 32'h11);
		repeat (20) @(posedge pclk);
		chk(pins_out.sck_oe | pins_out.sdo_oe, 1'b0, "reserved mode pins");
		$display("test rates done");
		apb(1'b1, `ADDR_CTRL, 32'h0);
		apb(1'b1, `ADDR_AUX, 32'h3);
		rd_chk(`ADDR_AUX, 32'h2, "clock idles low");
		apb(1'b1, `ADDR_CTRL, 32'h24);
		apb(1'b1, `ADDR_BUFFER, 32'hC3);
		spi_far_end_inst.xfer(8'h96, 8, got);
		repeat (4) @(posedge pclk);
		chk(got, 8'hC3, "slave sent");
		chk(irq, 1'b1, "slave done");
		chk(wakes, 1, "wake pulse");
		spi_far_end_inst.xfer(8'h69, 8, got);
		repeat (4) @(posedge pclk);
		rd_chk(`ADDR_CTRL, 32'h64, "overflow");
		rd_chk(`ADDR_BUFFER, 32'h96, "old byte kept");
		spi_far_end_inst.xfer(8'hFF, 3, got);
		spi_far_end_inst.xfer(8'h5A, 8, got);
		repeat (4) @(posedge pclk);
		rd_chk(`ADDR_BUFFER, 32'h5A, "count restarted");
		$display("test slave done");
		apb(1'b1, `ADDR_CTRL, 32'h0);
		apb(1'b1, `ADDR_CTRL, 32'h22);
		apb(1'b1, `ADDR_BUFFER, 32'hFF);
		repeat (10) @(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		#1 chk(pins_out.sck_oe, 1'b0, "reset releases clock");
		@(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`ADDR_CTRL, 32'h0, "reset disables");
		rd_chk(`ADDR_AUX, 32'h0, "reset aborts");
		$display("test reset abort done");
		conclude();
	end
endmodule
